// ==== rtl/iops_pkg.sv ====
// Overview of operation
// - A management or front-panel power-on request starts the power-up sequence.
// - A power-on request drives the active-low supply-on request low.
// - Combined supply-ok is the OR of power-OK from every installed supply.
// - The 5 V converter enable equals combined supply-ok AND management converter enable.
// - The hub core rail enable follows 5 V converter power good.
// - The bridge core rail enable follows 5 V converter power good.
// - System power good needs 3.3 V good, node good, then 200 ms stable.
// - Drive converter enables and watch their power-good outputs to order the rails.
// - Sequence ends with rails up, clocks enabled, power-on reset still held.
// - Latch a converter fault when present and enabled but power good stays low.
// - Faults survive main power loss; clear on standby loss or healthy re-power.
package iops_pkg;
	localparam int unsigned CLK_PERIOD_NS = 5;
	localparam int unsigned STABLE_TIME_MS = 200;
	localparam int unsigned STABLE_CYCLES = STABLE_TIME_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned PG_TIMEOUT_MS = 10;
	localparam int unsigned PG_TIMEOUT_CYCLES = PG_TIMEOUT_MS * 1000000 / CLK_PERIOD_NS;
	localparam int unsigned NUM_SUPPLIES = 2;
	localparam int unsigned NUM_CONVERTERS = 4;
	// Converter slots 0 and 1 carry 5 V, slots 2 and 3 carry 3.3 V
	localparam int unsigned FIVE_SLOT_LO = 0;
	localparam int unsigned THREE_SLOT_LO = 2;
	localparam int unsigned SYNC_STAGES = 2;

	typedef enum logic [2:0] {
		ST_OFF = 3'b000,
		ST_SUPPLY_WAIT = 3'b001,
		ST_FIVE_UP = 3'b010,
		ST_CORE_UP = 3'b011,
		ST_RUNNING = 3'b100
	} iops_state_e;
endpackage

// ==== rtl/iops_sync.sv ====
`timescale 1ns/10ps
module iops_sync #(
	parameter int unsigned WIDTH = 1
) (
	input wire logic i_clk,
	input wire logic i_reset_n,
	input wire logic [WIDTH-1:0] i_async,
	output logic [WIDTH-1:0] o_sync
);
	typedef struct packed {
		logic [WIDTH-1:0] meta;
		logic [WIDTH-1:0] sync;
	} iops_sync_s;

	iops_sync_s st_reg;
	iops_sync_s st_next;

	// Only the second stage feeds logic
	always_comb begin
		st_next.meta = i_async;
		st_next.sync = st_reg.meta;
	end

	always_ff @(posedge i_clk or negedge i_reset_n) begin
		if (!i_reset_n) begin
			st_reg <= '0;
		end else begin
			st_reg <= st_next;
		end
	end

	assign o_sync = st_reg.sync;
endmodule

// ==== rtl/iops_sequencer.sv ====
`timescale 1ns/10ps
module iops_sequencer #(
	parameter int unsigned NUM_SUPPLIES = iops_pkg::NUM_SUPPLIES,
	parameter int unsigned STABLE_CYCLES = iops_pkg::STABLE_CYCLES,
	parameter int unsigned PG_TIMEOUT_CYCLES = iops_pkg::PG_TIMEOUT_CYCLES
) (
	input wire logic I_CORE_CLK,
	input wire logic I_RESET_N,
	input wire logic I_MGMT_POWER_ON_REQ,
	input wire logic I_PANEL_POWER_ON_REQ,
	input wire logic [NUM_SUPPLIES-1:0] I_SUPPLY_INSTALLED,
	input wire logic [NUM_SUPPLIES-1:0] I_SUPPLY_OK,
	input wire logic I_MGMT_CONVERTER_ENABLE,
	input wire logic [iops_pkg::NUM_CONVERTERS-1:0] I_CONVERTER_PRESENT_N,
	input wire logic [iops_pkg::NUM_CONVERTERS-1:0] I_CONVERTER_POWER_GOOD,
	input wire logic I_HUB_CORE_GOOD,
	input wire logic I_BRIDGE_CORE_GOOD,
	input wire logic I_NODE_POWER_GOOD,
	output logic O_SUPPLY_ON_REQUEST_N,
	output logic O_ANY_SUPPLY_OK,
	output logic [iops_pkg::NUM_CONVERTERS-1:0] O_CONVERTER_OUTPUT_ENABLE,
	output logic O_HUB_CORE_RAIL_ENABLE,
	output logic O_BRIDGE_CORE_RAIL_ENABLE,
	output logic O_CLOCK_ENABLE,
	output logic O_POWER_ON_RESET_N,
	output logic O_SYSTEM_POWER_GOOD,
	output logic [iops_pkg::NUM_CONVERTERS-1:0] O_CONVERTER_FAULT
);
	localparam int unsigned NCONV = iops_pkg::NUM_CONVERTERS;
	localparam int unsigned SW = (STABLE_CYCLES > 1) ? $clog2(STABLE_CYCLES + 1) : 1;
	localparam int unsigned TW = (PG_TIMEOUT_CYCLES > 1) ? $clog2(PG_TIMEOUT_CYCLES + 1) : 1;
	localparam int unsigned SYNC_W = 2 + 2 * NUM_SUPPLIES + 1 + 2 * NCONV + 3;
	localparam logic [SW-1:0] STABLE_LAST = SW'(STABLE_CYCLES);
	localparam logic [TW-1:0] TIMEOUT_LAST = TW'(PG_TIMEOUT_CYCLES);

	typedef struct packed {
		iops_pkg::iops_state_e state;
		logic supply_on_n;
		logic any_ok;
		logic five_en;
		logic three_en;
		logic hub_en;
		logic bridge_en;
		logic clk_en;
		logic sys_pg;
		logic [SW-1:0] stable_cnt;
		logic [NCONV-1:0][TW-1:0] pg_timer;
		logic [NCONV-1:0] fault;
	} iops_state_s;

	iops_state_s st_reg;
	iops_state_s st_next;

	logic [SYNC_W-1:0] sync_in;
	logic [SYNC_W-1:0] sync_out;
	logic req_mgmt;
	logic req_panel;
	logic [NUM_SUPPLIES-1:0] sup_inst;
	logic [NUM_SUPPLIES-1:0] sup_ok;
	logic mgmt_conv_en;
	logic [NCONV-1:0] conv_present;
	logic [NCONV-1:0] conv_pg;
	logic hub_good;
	logic bridge_good;
	logic node_good;
	logic req_any;
	logic five_good;
	logic three_good;
	logic [NCONV-1:0] conv_en;

	assign sync_in = {I_MGMT_POWER_ON_REQ, I_PANEL_POWER_ON_REQ, I_SUPPLY_INSTALLED, I_SUPPLY_OK,
		I_MGMT_CONVERTER_ENABLE, ~I_CONVERTER_PRESENT_N, I_CONVERTER_POWER_GOOD,
		I_HUB_CORE_GOOD, I_BRIDGE_CORE_GOOD, I_NODE_POWER_GOOD};

	iops_sync #(
		.WIDTH(SYNC_W)
	) u_sync (
		.i_clk(I_CORE_CLK),
		.i_reset_n(I_RESET_N),
		.i_async(sync_in),
		.o_sync(sync_out)
	);

	assign {req_mgmt, req_panel, sup_inst, sup_ok, mgmt_conv_en, conv_present, conv_pg,
		hub_good, bridge_good, node_good} = sync_out;

	assign req_any = req_mgmt | req_panel;
	// Rail good means at least one converter on that rail is present and every present one reports good
	assign five_good = &(conv_pg[iops_pkg::FIVE_SLOT_LO +: 2] | ~conv_present[iops_pkg::FIVE_SLOT_LO +: 2])
		& |conv_present[iops_pkg::FIVE_SLOT_LO +: 2];
	assign three_good = &(conv_pg[iops_pkg::THREE_SLOT_LO +: 2] | ~conv_present[iops_pkg::THREE_SLOT_LO +: 2])
		& |conv_present[iops_pkg::THREE_SLOT_LO +: 2];
	assign conv_en = {{2{st_reg.three_en}}, {2{st_reg.five_en}}};

	always_comb begin
		st_next = st_reg;
		st_next.any_ok = |(sup_ok & sup_inst);
		case (st_reg.state)
			iops_pkg::ST_OFF: begin
				if (req_any) begin
					st_next.state = iops_pkg::ST_SUPPLY_WAIT;
				end
			end
			iops_pkg::ST_SUPPLY_WAIT: begin
				if (st_reg.any_ok) begin
					st_next.state = iops_pkg::ST_FIVE_UP;
				end
			end
			iops_pkg::ST_FIVE_UP: begin
				if (five_good) begin
					st_next.state = iops_pkg::ST_CORE_UP;
				end
			end
			iops_pkg::ST_CORE_UP: begin
				if (three_good && hub_good && bridge_good) begin
					st_next.state = iops_pkg::ST_RUNNING;
				end
			end
			iops_pkg::ST_RUNNING: begin
				if (!five_good) begin
					st_next.state = iops_pkg::ST_FIVE_UP;
				end else if (!three_good || !hub_good || !bridge_good) begin
					st_next.state = iops_pkg::ST_CORE_UP;
				end
			end
			default: begin
				st_next.state = iops_pkg::ST_OFF;
			end
		endcase
		if (!req_any) begin
			st_next.state = iops_pkg::ST_OFF;
		end else if (!st_reg.any_ok && st_reg.state != iops_pkg::ST_OFF) begin
			st_next.state = iops_pkg::ST_SUPPLY_WAIT;
		end
		st_next.supply_on_n = !req_any;
		st_next.five_en = st_reg.any_ok & mgmt_conv_en;
		st_next.hub_en = five_good & st_reg.five_en;
		st_next.bridge_en = five_good & st_reg.five_en;
		st_next.three_en = five_good & st_reg.five_en;
		st_next.clk_en = (st_next.state == iops_pkg::ST_RUNNING) && st_next.hub_en && st_next.bridge_en
			&& st_next.three_en;
		if (!five_good || !three_good || !node_good || st_reg.state != iops_pkg::ST_RUNNING) begin
			st_next.stable_cnt = '0;
		end else if (st_reg.stable_cnt != STABLE_LAST) begin
			st_next.stable_cnt = st_reg.stable_cnt + SW'(1);
		end
		st_next.sys_pg = five_good && three_good && node_good && st_reg.state == iops_pkg::ST_RUNNING
			&& st_reg.stable_cnt == STABLE_LAST;
		for (int i = 0; i < NCONV; i++) begin
			if (conv_present[i] && conv_en[i] && !conv_pg[i]) begin
				if (st_reg.pg_timer[i] != TIMEOUT_LAST) begin
					st_next.pg_timer[i] = st_reg.pg_timer[i] + TW'(1);
				end
			end else begin
				st_next.pg_timer[i] = '0;
			end
			if (conv_present[i] && conv_en[i] && conv_pg[i]) begin
				st_next.fault[i] = 1'b0;
			end
			if (st_reg.pg_timer[i] == TIMEOUT_LAST && conv_present[i] && conv_en[i] && !conv_pg[i]) begin
				st_next.fault[i] = 1'b1;
			end
		end
	end

	always_ff @(posedge I_CORE_CLK or negedge I_RESET_N) begin
		if (!I_RESET_N) begin
			st_reg <= '{state: iops_pkg::ST_OFF, supply_on_n: 1'b1, default: '0};
		end else begin
			st_reg <= st_next;
		end
	end

	assign O_SUPPLY_ON_REQUEST_N = st_reg.supply_on_n;
	assign O_ANY_SUPPLY_OK = st_reg.any_ok;
	assign O_CONVERTER_OUTPUT_ENABLE = conv_en;
	assign O_HUB_CORE_RAIL_ENABLE = st_reg.hub_en;
	assign O_BRIDGE_CORE_RAIL_ENABLE = st_reg.bridge_en;
	assign O_CLOCK_ENABLE = st_reg.clk_en;
	// Reset release belongs to a later stage
	assign O_POWER_ON_RESET_N = 1'b0;
	assign O_SYSTEM_POWER_GOOD = st_reg.sys_pg;
	assign O_CONVERTER_FAULT = st_reg.fault;

	default clocking cb @(posedge I_CORE_CLK);
	endclocking
	default disable iff (!I_RESET_N);

	property p_request_supply;
		req_any |=> !O_SUPPLY_ON_REQUEST_N;
	endproperty
	a_request_supply: assert property (p_request_supply) else $error("supply request not driven");

	property p_any_ok;
		O_ANY_SUPPLY_OK |-> $past(|(sup_ok & sup_inst));
	endproperty
	a_any_ok: assert property (p_any_ok) else $error("supply ok without installed ok");

	property p_five_enable;
		##1 (O_CONVERTER_OUTPUT_ENABLE[0] == $past(st_reg.any_ok && mgmt_conv_en));
	endproperty
	a_five_enable: assert property (p_five_enable) else $error("five volt enable mismatch");

	property p_hub_enable;
		(five_good && st_reg.five_en) |=> O_HUB_CORE_RAIL_ENABLE;
	endproperty
	a_hub_enable: assert property (p_hub_enable) else $error("hub rail not enabled");

	property p_bridge_enable;
		O_BRIDGE_CORE_RAIL_ENABLE |-> $past(five_good);
	endproperty
	a_bridge_enable: assert property (p_bridge_enable) else $error("bridge rail without five good");

	property p_power_good;
		O_SYSTEM_POWER_GOOD |-> $past(st_reg.stable_cnt == STABLE_LAST && three_good && node_good);
	endproperty
	a_power_good: assert property (p_power_good) else $error("power good too early");

	property p_clock_order;
		O_CLOCK_ENABLE |-> (O_HUB_CORE_RAIL_ENABLE && O_CONVERTER_OUTPUT_ENABLE[2] && !O_POWER_ON_RESET_N);
	endproperty
	a_clock_order: assert property (p_clock_order) else $error("clocks before rails");

	property p_fault_cause;
		$rose(O_CONVERTER_FAULT[0]) |-> $past(conv_en[0] && !conv_pg[0] && st_reg.pg_timer[0] == TIMEOUT_LAST);
	endproperty
	a_fault_cause: assert property (p_fault_cause) else $error("fault without cause");

	property p_fault_hold;
		(O_CONVERTER_FAULT[1] && !conv_en[1]) |=> O_CONVERTER_FAULT[1];
	endproperty
	a_fault_hold: assert property (p_fault_hold) else $error("fault lost while off");

	property p_good_drop;
		(O_SYSTEM_POWER_GOOD && !node_good) |=> !O_SYSTEM_POWER_GOOD ##1 !O_SYSTEM_POWER_GOOD;
	endproperty
	a_good_drop: assert property (p_good_drop) else $error("power good held after drop");

	property p_count_clear;
		!(three_good && node_good) |=> (st_reg.stable_cnt == '0);
	endproperty
	a_count_clear: assert property (p_count_clear) else $error("stable count not cleared");

	c_running: cover property (st_reg.state == iops_pkg::ST_CORE_UP ##1 st_reg.state == iops_pkg::ST_RUNNING);
	c_power_good: cover property ($rose(O_SYSTEM_POWER_GOOD));
	c_fault: cover property ($rose(O_CONVERTER_FAULT[0]));
	c_good_drop: cover property ($fell(O_SYSTEM_POWER_GOOD) && req_any);
endmodule

// ==== sim/iops_far_model.sv ====
`timescale 1ns/10ps
module iops_far_model (
	input wire logic i_clk,
	input wire logic i_supply_on_n,
	input wire logic [3:0] i_conv_en,
	input wire logic i_hub_en,
	input wire logic i_bridge_en,
	input wire logic [7:0] i_delay,
	input wire logic [3:0] i_broken,
	output logic [1:0] o_supply_ok,
	output logic [3:0] o_conv_good,
	output logic o_hub_good,
	output logic o_bridge_good
);
	logic [7:0] en;
	logic [7:0] up;
	logic [7:0] cnt [8] = '{default: 8'h00};
	assign en = {i_bridge_en, i_hub_en, i_conv_en, {2{~i_supply_on_n}}};
	// Good follows enable after i_delay cycles, drops at once
	always @(posedge i_clk) begin
		for (int i = 0; i < 8; i++) begin
			cnt[i] <= !en[i] ? 8'h00 : (cnt[i] == 8'hff ? cnt[i] : cnt[i] + 8'h01);
		end
	end
	always_comb begin
		for (int i = 0; i < 8; i++) begin
			up[i] = en[i] && cnt[i] >= i_delay;
		end
	end
	assign o_supply_ok = up[1:0];
	// A broken converter never reports good
	assign o_conv_good = up[5:2] & ~i_broken;
	assign o_hub_good = up[6];
	assign o_bridge_good = up[7];
endmodule

// ==== sim/io_board_power_sequencer_bench.sv ====
`timescale 1ns/10ps
module io_board_power_sequencer_bench;
	localparam int STABLE = 20;
	logic clk, rst_n, mgmt_req, panel_req, mgmt_en, node_good, hub_good, bridge_good;
	logic supply_on_n, any_ok, hub_en, bridge_en, clk_en, por_n, sys_good;
	logic [1:0] installed, supply_ok;
	logic [3:0] present_n, broken, conv_good, conv_en, fault;
	logic [7:0] delay;
	int n_mismatch = 0;
	int n_checks = 0;
	iops_sequencer #(.STABLE_CYCLES(STABLE), .PG_TIMEOUT_CYCLES(10)) dut_u (.I_CORE_CLK(clk), .I_RESET_N(rst_n),
		.I_MGMT_POWER_ON_REQ(mgmt_req), .I_PANEL_POWER_ON_REQ(panel_req), .I_SUPPLY_INSTALLED(installed),
		.I_SUPPLY_OK(supply_ok), .I_MGMT_CONVERTER_ENABLE(mgmt_en), .I_CONVERTER_PRESENT_N(present_n),
		.I_CONVERTER_POWER_GOOD(conv_good), .I_HUB_CORE_GOOD(hub_good), .I_BRIDGE_CORE_GOOD(bridge_good),
		.I_NODE_POWER_GOOD(node_good), .O_SUPPLY_ON_REQUEST_N(supply_on_n), .O_ANY_SUPPLY_OK(any_ok),
		.O_CONVERTER_OUTPUT_ENABLE(conv_en), .O_HUB_CORE_RAIL_ENABLE(hub_en), .O_BRIDGE_CORE_RAIL_ENABLE(bridge_en),
		.O_CLOCK_ENABLE(clk_en), .O_POWER_ON_RESET_N(por_n), .O_SYSTEM_POWER_GOOD(sys_good), .O_CONVERTER_FAULT(fault));
	iops_far_model far_u (.i_clk(clk), .i_supply_on_n(supply_on_n), .i_conv_en(conv_en), .i_hub_en(hub_en),
		.i_bridge_en(bridge_en), .i_delay(delay), .i_broken(broken), .o_supply_ok(supply_ok),
		.o_conv_good(conv_good), .o_hub_good(hub_good), .o_bridge_good(bridge_good));
	initial begin
		clk = 1'h0;
		forever #2.5 clk = ~clk;
	end
	task automatic chk(input string name, input logic [3:0] seen, input logic [3:0] exp);
		n_checks++;
		if (seen !== exp) begin
			n_mismatch++;
			$display("[ERR] %s expected %h seen %h", name, exp, seen);
		end
	endtask
	task automatic step(input int n);
		repeat (n) @(posedge clk);
		#1;
	endtask
	task automatic measure_pg(input int lo);
		int i;
		for (i = 0; i < 40 && sys_good !== 1'h1; i++) step(1);
		chk("pg_delay", 4'(i >= lo && i <= STABLE + 5), 4'h1); // stable delay
	endtask
	task automatic power_up(input logic by_panel);
		int i;
		mgmt_req = !by_panel;
		panel_req = by_panel;
		for (i = 0; i < 10 && supply_on_n !== 1'h0; i++) step(1);
		chk("supply_on_n", 4'(supply_on_n), 4'h0); // supplies requested
		for (i = 0; i < 200 && clk_en !== 1'h1; i++) step(1);
		chk("any_ok", 4'(any_ok), 4'h1); // supplies combined
		chk("conv_en", conv_en, 4'hf); // converters on
		chk("core_en", {2'h0, hub_en, bridge_en}, 4'h3); // core rails
		chk("clk_por", {2'h0, clk_en, por_n}, 4'h2); // reset held
		measure_pg(STABLE - 2);
		$display("test power_up done");
	endtask
	task automatic t_gate_and_or;
		int i;
		mgmt_en = 1'h0;
		step(6);
		chk("five_en", {2'h0, conv_en[1:0]}, 4'h0); // mgmt gate
		chk("core_off", {1'h0, hub_en, bridge_en, sys_good}, 4'h0); // follow good
		mgmt_en = 1'h1;
		installed = 2'h0;
		step(6);
		chk("any_ok_none", 4'(any_ok), 4'h0); // uninstalled ignored
		installed = 2'h1;
		step(6);
		chk("any_ok_one", 4'(any_ok), 4'h1); // single supply
		installed = 2'h3;
		for (i = 0; i < 300 && sys_good !== 1'h1; i++) step(1);
		chk("sys_good", 4'(sys_good), 4'h1); // recovered
		$display("test gate_and_or done");
	endtask
	task automatic t_restart;
		node_good = 1'h0;
		step(5);
		chk("pg_drop", 4'(sys_good), 4'h0); // good lost
		node_good = 1'h1;
		measure_pg(STABLE);
		$display("test restart done");
	endtask
	task automatic t_fault;
		int i;
		mgmt_req = 1'h0;
		step(8);
		chk("off", {2'h0, supply_on_n, sys_good}, 4'h2); // request dropped
		broken = 4'h1;
		panel_req = 1'h1;
		for (i = 0; i < 200 && fault[0] !== 1'h1; i++) step(1);
		chk("fault_set", fault, 4'h1); // missing good
		panel_req = 1'h0;
		step(20);
		chk("fault_kept", fault, 4'h1); // survives power off
		broken = 4'h0;
		delay = 8'h08;
		power_up(1'h1);
		chk("fault_clr", fault, 4'h0); // healthy repower
		broken = 4'h8;
		for (i = 0; i < 200 && fault[3] !== 1'h1; i++) step(1);
		chk("fault_3v", fault, 4'h8); // slot three
		rst_n = 1'h0;
		step(4);
		rst_n = 1'h1;
		step(1);
		chk("fault_rst", fault, 4'h0); // standby loss
		$display("test fault done");
	endtask
	task automatic print_verdict;
		$display("checks %0d mismatches %0d", n_checks, n_mismatch);
		if (n_mismatch == 0 && n_checks > 0) begin
			$display("Finished cleanly");
		end else begin
			$display("Finished with errors");
		end
		$finish;
	endtask
	initial begin
		#40000;
		n_mismatch++;
		print_verdict();
	end
	initial begin
		{rst_n, mgmt_req, panel_req, broken} = 7'h00;
		{installed, mgmt_en, present_n, node_good, delay} = 16'h6102;
		step(4);
		rst_n = 1'h1;
		step(2);
		power_up(1'h0);
		t_gate_and_or();
		t_restart();
		t_fault();
		print_verdict();
	end
endmodule
